/* File: hw/power_supervisor_consts.vh */
// Constants for the power supervisor and sleep controller.
`ifndef POWER_SUPERVISOR_CONSTS_VH
`define POWER_SUPERVISOR_CONSTS_VH
`define PS_CLK_PERIOD_NS   10
`define PS_WDT_TICK_NS     1000000
`define PS_WDT_TICK_CYCLES (`PS_WDT_TICK_NS / `PS_CLK_PERIOD_NS)
`define PS_WDT_WIDTH       16
`define PS_RTC_WIDTH       64
`define PS_SLOW_OSC_HZ     31250
`define PS_STEP_NS         1000
`define PS_STEP_CYCLES     (`PS_STEP_NS / `PS_CLK_PERIOD_NS)
`define PS_DSM_BYTES       128
`define PS_DSM_ADDR_W      7
`define PS_RTC_INC_RESET   64'h0000000000000C80
`endif

/* File: hw/power_supervisor_sleep_controller.v */
// Supervisor resets, watchdog, power-mode sequencer, real-time counter and deep-sleep memory.
// Contract
// [RL1] Hold chip reset until all supplies good.
// [RL2] Supply loss resets chip, restart as cold.
// [RL3] External active-low reset optional, pulled inactive; the code adds no pull of its own and relies on the pad.
// [RL4] Sixteen-bit watchdog counting one millisecond ticks.
// [RL5] Watchdog timebase independent of real-time counter.
// [RL6] Watchdog expiry before re-arm resets chip.
// [RL7] Status bit flags watchdog as last reset; an external reset after it leaves the bit set.
// [RL8] Watchdog runs only in the running state.
// [RL9] Intermediate states sequence power-down and power-up.
// [RL10] Control write starts running-to-sleep transition.
// [RL11] Software requests sleep only while running.
// [RL12] Wake stimuli honoured only while sleeping.
// [RL13] Wake during power-down remembered until asleep.
// [RL14] Wake pin edge or level, polarity selectable.
// [RL15] Counter reaching compare value raises wake.
// [RL16] Running: counter adds one every clock.
// [RL17] Asleep on slow oscillator: add programmable increment.
// [RL18] Asleep: core and peripherals powered down.
// [RL19] 128-byte memory retained through sleep.
// [RL20] Supply loss during transitions forces system reset.
// [RL21] Software picks lowest-power sleep configuration.
// [RL22] Switched I/O supply on only while running.
// [RL23] Wake sequence reverses power-down, one step each.
`timescale 1ns/1ps
`default_nettype none
`include "power_supervisor_consts.vh"
module power_supervisor_sleep_controller #(
  parameter NUM_SUPPLIES = 3,
  parameter WDT_TICK_CYCLES = `PS_WDT_TICK_CYCLES,
  parameter STEP_CYCLES = `PS_STEP_CYCLES
) (
  // Clock and reset
  input  wire                          clk,
  input  wire                          sys_rst,
  // Supply monitors and external pins
  input  wire [NUM_SUPPLIES-1:0]       supplyGood,
  input  wire                          extReset_n,
  input  wire                          wakePin,
  input  wire                          slowOscTick,
  // Watchdog control
  input  wire                          wdtEnable,
  input  wire                          wdtArm,
  input  wire [`PS_WDT_WIDTH-1:0]      wdtTimeout,
  output reg                           wdtResetCause,
  // Power mode control
  input  wire                          sleepRequest,
  input  wire                          wakePinEnable,
  input  wire                          wakePinPolarity,
  input  wire                          wakePinEdge,
  input  wire                          wakeTimerEnable,
  input  wire                          sleepSlowClock,
  input  wire [`PS_RTC_WIDTH-1:0]      rtcCompare,
  input  wire [`PS_RTC_WIDTH-1:0]      rtcIncrement,
  output reg  [4:0]                    powerState,
  // Real-time counter
  output reg  [`PS_RTC_WIDTH-1:0]      rtcCount,
  // Deep-sleep memory
  input  wire                          dsmWrite,
  input  wire [`PS_DSM_ADDR_W-1:0]     dsmAddr,
  input  wire [7:0]                    dsmWriteData,
  output reg  [7:0]                    dsmReadData,
  // Power and reset outputs
  output reg                           chipReset,
  output reg                           coreOn,
  output reg                           switched_io_supply
);

  localparam [4:0] ST_AWAKE     = 5'h01;
  localparam [4:0] ST_DOWN_CORE = 5'h02;
  localparam [4:0] ST_DOWN_IO   = 5'h04;
  localparam [4:0] ST_ASLEEP    = 5'h08;
  localparam [4:0] ST_UP_IO     = 5'h10;
  // The last power-up step has no spare bit in the 5-bit state port, so it is all zeros.
  localparam [4:0] ST_UP_CORE   = 5'h00;

  // Counter step shared by the sequencer and the watchdog prescaler.
  function [31:0] incr32;
    input [31:0] value;
    begin
      incr32 = value + 32'h00000001;
    end
  endfunction

  // True in the two power-down steps, where wake stimuli must be remembered.
  function isPowerDown;
    input [4:0] state;
    begin
      isPowerDown = (state == ST_DOWN_CORE) || (state == ST_DOWN_IO);
    end
  endfunction

  // True in the states that keep the digital core supplied.
  function coreSupplied;
    input [4:0] state;
    begin
      coreSupplied = (state == ST_AWAKE) || (state == ST_UP_CORE);
    end
  endfunction

  // Two-flop synchronisers for all pin inputs; stage one feeds stage two only.
  reg [NUM_SUPPLIES-1:0] goodMeta;
  reg [NUM_SUPPLIES-1:0] goodSync;
  reg [2:0]              pinMeta;
  reg [2:0]              pinSync;
  reg                    wakePinLast;
  reg                    slowLast;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      goodMeta    <= {NUM_SUPPLIES{1'b0}};
      goodSync    <= {NUM_SUPPLIES{1'b0}};
      pinMeta     <= 3'h1;
      pinSync     <= 3'h1;
      wakePinLast <= 1'b0;
      slowLast    <= 1'b0;
    end else begin
      goodMeta    <= supplyGood;
      goodSync    <= goodMeta;
      pinMeta     <= {slowOscTick, wakePin, extReset_n};
      pinSync     <= pinMeta;
      wakePinLast <= pinSync[1];
      slowLast    <= pinSync[2];
    end
  end

  wire allGood = &goodSync;
  // An unconnected reset pin must be tied or pulled high at the pad.
  wire extResetActive = ~pinSync[0]; // [RL3]
  wire wakeLevel = pinSync[1];
  wire slowTick = pinSync[2] & ~slowLast;

  reg  [4:0] next_powerState;
  // One step counter serves every transit state, so each step lasts the same time.
  reg  [31:0] stepCount;
  wire stepDone = (stepCount == STEP_CYCLES - 1);
  reg  wakePending;
  reg  wdtExpired;
  reg  [31:0] tickCount;
  reg  [`PS_WDT_WIDTH-1:0] wdtCount;
  wire [`PS_WDT_WIDTH-1:0] wdtNext = wdtCount + 16'h0001;

  // Edge mode fires only on a move into the selected level.
  wire pinWake = wakePinEnable &&
    (wakePinEdge ? ((wakeLevel != wakePinLast) && (wakeLevel == wakePinPolarity))
                 : (wakeLevel == wakePinPolarity)); // [RL14]
  wire timerWake = wakeTimerEnable && (rtcCount >= rtcCompare); // [RL15]
  wire wakeEvent = pinWake | timerWake;
  // Any fault restarts the sequencer from the awake state, as after a cold start.
  wire faultReset = ~allGood | extResetActive | wdtExpired; // [RL1] [RL2] [RL20]

  always @* begin
    next_powerState = powerState;
    case (powerState)
      ST_AWAKE: begin
        if (sleepRequest) begin
          next_powerState = ST_DOWN_CORE; // [RL10] [RL11]
        end
      end
      ST_DOWN_CORE: begin
        if (stepDone) begin
          next_powerState = ST_DOWN_IO; // [RL9]
        end
      end
      ST_DOWN_IO: begin
        if (stepDone) begin
          next_powerState = ST_ASLEEP; // [RL9]
        end
      end
      ST_ASLEEP: begin
        if (wakePending | wakeEvent) begin
          next_powerState = ST_UP_IO; // [RL12] [RL13]
        end
      end
      ST_UP_IO: begin
        if (stepDone) begin
          next_powerState = ST_UP_CORE; // [RL23]
        end
      end
      ST_UP_CORE: begin
        if (stepDone) begin
          next_powerState = ST_AWAKE; // [RL23]
        end
      end
      default: begin
        next_powerState = ST_AWAKE;
      end
    endcase
  end

  // Outputs look one state ahead so that they switch with the state register.
  wire [4:0] stateAfter = faultReset ? ST_AWAKE : next_powerState;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerState <= ST_AWAKE;
      stepCount  <= 32'h00000000;
    end else if (faultReset) begin
      powerState <= ST_AWAKE; // [RL2] [RL20]
      stepCount  <= 32'h00000000;
    end else begin
      powerState <= next_powerState;
      if (next_powerState != powerState || stepDone) begin
        stepCount <= 32'h00000000;
      end else begin
        stepCount <= incr32(stepCount);
      end
    end
  end

  // Wake memory fills only while powering down; leaving that path empties it.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakePending <= 1'b0;
    end else if (faultReset) begin
      wakePending <= 1'b0;
    end else if (isPowerDown(powerState)) begin
      wakePending <= wakePending | wakeEvent; // [RL13]
    end else begin
      wakePending <= 1'b0; // [RL12]
    end
  end

  // Watchdog on its own millisecond prescaler, never on the real-time counter.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCount     <= 32'h00000000;
      wdtCount      <= {`PS_WDT_WIDTH{1'b0}};
      wdtExpired    <= 1'b0;
      wdtResetCause <= 1'b0;
    end else begin
      wdtExpired <= 1'b0;
      // The cause bit survives the reset that it reports; only sys_rst or a supply loss clears it.
      if (wdtExpired) begin
        wdtResetCause <= 1'b1; // [RL7]
      end else if (~allGood) begin
        wdtResetCause <= 1'b0;
      end
      if (!wdtEnable || powerState != ST_AWAKE || wdtArm || faultReset) begin
        tickCount <= 32'h00000000; // [RL8]
        wdtCount  <= {`PS_WDT_WIDTH{1'b0}};
      end else if (tickCount == WDT_TICK_CYCLES - 1) begin
        tickCount <= 32'h00000000; // [RL5]
        if (wdtNext >= wdtTimeout) begin
          wdtExpired <= 1'b1; // [RL6]
          wdtCount   <= {`PS_WDT_WIDTH{1'b0}};
        end else begin
          wdtCount <= wdtNext; // [RL4]
        end
      end else begin
        tickCount <= incr32(tickCount);
      end
    end
  end

  // Real-time counter.
  // Asleep without the slow clock selected, it keeps counting at the main-clock pace.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rtcCount <= {`PS_RTC_WIDTH{1'b0}};
    end else if (powerState == ST_ASLEEP && sleepSlowClock) begin
      if (slowTick) begin
        rtcCount <= rtcCount + rtcIncrement; // [RL17]
      end
    end else begin
      rtcCount <= rtcCount + 64'h0000000000000001; // [RL16]
    end
  end

  // Deep-sleep memory is cleared only by sys_rst, not by a supply loss or the watchdog.
  reg [7:0] dsm [0:`PS_DSM_BYTES-1];
  integer i;
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (i = 0; i < `PS_DSM_BYTES; i = i + 1) begin
        dsm[i] <= 8'h00;
      end
      dsmReadData <= 8'h00;
    end else begin
      // Writes outside the awake state are dropped, since no software runs there.
      if (dsmWrite && powerState == ST_AWAKE) begin
        dsm[dsmAddr] <= dsmWriteData; // [RL19]
      end
      dsmReadData <= dsm[dsmAddr];
    end
  end

  // Outputs.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chipReset          <= 1'b1;
      coreOn             <= 1'b0;
      switched_io_supply <= 1'b0;
    end else begin
      // Registered so that the reset output never glitches on a combinational path.
      chipReset          <= faultReset; // [RL1] [RL2] [RL6]
      coreOn             <= coreSupplied(stateAfter); // [RL18]
      switched_io_supply <= (stateAfter == ST_AWAKE) & ~faultReset; // [RL22]
    end
  end

endmodule // power_supervisor_sleep_controller
`default_nettype wire

/* File: sim/power_supervisor_props.sv */
// Port-level checks on the supervisor and power-mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module power_supervisor_props #(
  parameter int NUM_SUPPLIES = 3,
  parameter int STEP_CYCLES  = 100
) (
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    sys_rst,
  // Inputs
  input wire logic [NUM_SUPPLIES-1:0] supplyGood,
  input wire logic                    extReset_n,
  input wire logic                    sleepRequest,
  // Outputs
  input wire logic [4:0]              powerState,
  input wire logic [63:0]             rtcCount,
  input wire logic                    chipReset,
  input wire logic                    coreOn,
  input wire logic                    switched_io_supply
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [4:0] prevState;
  int         dwell;
  // A counter keeps long step lengths out of unrolled repetitions.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevState <= 5'h01;
      dwell     <= 0;
    end else begin
      prevState <= powerState;
      dwell     <= (powerState == prevState) ? dwell + 1 : 0;
    end
  end
  sequence s_goDown;
    powerState == 5'h01 && sleepRequest && !chipReset;
  endsequence
  a_sleep_start: assert property (s_goDown |=> powerState == 5'h02 || chipReset)
    else $error("sleep request not taken");
  a_awake_hold: assert property (powerState == 5'h01 && !sleepRequest |=> powerState == 5'h01)
    else $error("awake state left without request");
  a_down_next: assert property (powerState == 5'h02 |=> powerState inside {5'h02, 5'h04, 5'h01})
    else $error("first power-down step left wrongly");
  a_core_off: assert property (powerState == 5'h08 |-> !coreOn)
    else $error("core powered while asleep");
  a_down_order: assert property (powerState == 5'h04 |=> powerState inside {5'h04, 5'h08, 5'h01})
    else $error("power-down order broken");
  a_up_reverse: assert property (powerState == 5'h10 |=> powerState inside {5'h10, 5'h00, 5'h01})
    else $error("power-up order broken");
  a_step_dwell: assert property (prevState inside {5'h02, 5'h04, 5'h10} && powerState != prevState
    && powerState != 5'h01 |-> dwell == STEP_CYCLES - 1) else $error("step length wrong");
  a_io_awake: assert property (switched_io_supply |-> powerState == 5'h01)
    else $error("switched supply on outside awake");
  a_supply_loss: assert property (!(&supplyGood) |-> ##[0:4] chipReset)
    else $error("supply loss without reset");
  a_ext_reset: assert property (!extReset_n |-> ##[0:4] chipReset)
    else $error("external reset ignored");
  a_rtc_tick: assert property ((powerState == 5'h01 && !chipReset)[*2] |->
    rtcCount == $past(rtcCount) + 64'h1) else $error("counter not stepping by one");
endmodule // power_supervisor_props
bind power_supervisor_sleep_controller power_supervisor_props #(
  .NUM_SUPPLIES(NUM_SUPPLIES), .STEP_CYCLES(STEP_CYCLES)) props (.clk, .sys_rst, .supplyGood,
  .extReset_n, .sleepRequest, .powerState, .rtcCount, .chipReset, .coreOn, .switched_io_supply);
`default_nettype wire

/* File: sim/supply_env_model.sv */
// Supply monitors, reset pin, wake pin and slow oscillator around the supervisor.
`timescale 1ns/1ps
`default_nettype none
module supply_env_model #(
  parameter int SLOW_HALF_NS = 160
) (
  // Bench commands
  input  wire logic       brownOut,
  input  wire logic       pressReset,
  input  wire logic       wakeLevel,
  // Pins
  output wire logic [2:0] supplyGood,
  output wire logic       extReset_n,
  output wire logic       wakePin,
  output var  logic       slowOscTick
);
  // Only one monitor drops, so a supervisor that ignores that middle supply is caught.
  assign supplyGood = brownOut ? 3'h5 : 3'h7;
  assign extReset_n = ~pressReset;
  assign wakePin    = wakeLevel;
  // The slow oscillator is shortened to keep sleeping runs brief.
  initial slowOscTick = 1'h0;
  always #(SLOW_HALF_NS) slowOscTick = ~slowOscTick;
endmodule // supply_env_model
`default_nettype wire

/* File: sim/tb_power_supervisor_sleep_controller.sv */
// Directed bench for the supervisor and power-mode sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_power_supervisor_sleep_controller;
  logic        clk = 1'h0, sys_rst = 1'h1, brownOut = 1'h0, pressReset = 1'h0;
  logic        wakeLevel = 1'h0, wdtEnable = 1'h0, wdtArm = 1'h0, sleepRequest = 1'h0;
  logic        wakePinEnable = 1'h1, wakePinPolarity = 1'h1, wakePinEdge = 1'h1;
  logic        wakeTimerEnable = 1'h0, sleepSlowClock = 1'h1, dsmWrite = 1'h0;
  logic [15:0] wdtTimeout = 16'h0003;
  logic [63:0] rtcCompare = 64'h0, rtcIncrement = 64'h20, r, rtcCount;
  logic [6:0]  dsmAddr = 7'h7F;
  logic [7:0]  dsmWriteData = 8'hA5, dsmReadData;
  logic [4:0]  powerState;
  logic [2:0]  supplyGood;
  logic        extReset_n, wakePin, slowOscTick, wdtResetCause, chipReset, coreOn;
  logic        switched_io_supply;
  int          n_mismatch = 0, total_checks = 0;
  always #5 clk = ~clk;
  supply_env_model env (.brownOut, .pressReset, .wakeLevel, .supplyGood, .extReset_n, .wakePin,
    .slowOscTick);
  power_supervisor_sleep_controller #(.WDT_TICK_CYCLES(10), .STEP_CYCLES(4)) dut (
    .clk, .sys_rst, .supplyGood, .extReset_n, .wakePin, .slowOscTick, .wdtEnable, .wdtArm,
    .wdtTimeout, .wdtResetCause, .sleepRequest, .wakePinEnable, .wakePinPolarity, .wakePinEdge,
    .wakeTimerEnable, .sleepSlowClock, .rtcCompare, .rtcIncrement, .powerState, .rtcCount,
    .dsmWrite, .dsmAddr, .dsmWriteData, .dsmReadData, .chipReset, .coreOn, .switched_io_supply);
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic waitFor(input logic [4:0] s, input logic rst, input int lim);
    int i;
    for (i = 0; i < lim && !(powerState === s && chipReset === rst); i++) @(negedge clk);
    if (!(powerState === s && chipReset === rst)) begin
      chk("wait", {s, rst}, {powerState, chipReset});
      summarize();
    end
  endtask
  task automatic nap;
    sleepSlowClock = 1'h1;
    sleepRequest = 1'h1;
    @(negedge clk);
    sleepRequest = 1'h0;
    chk("down", 64'h02, powerState);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'h0;
    waitFor(5'h01, 1'h0, 20);
    chk("io", 64'h1, switched_io_supply);
    chk("core", 64'h1, coreOn);
    r = rtcCount;
    repeat (5) @(negedge clk);
    chk("rtc", r + 64'h5, rtcCount);
    dsmWrite = 1'h1;
    @(negedge clk);
    dsmWrite = 1'h0;
    wakeLevel = 1'h1;
    repeat (8) @(negedge clk);
    chk("awake", 64'h01, powerState);
    wakeLevel = 1'h0;
    nap();
    wakeLevel = 1'h1;
    waitFor(5'h08, 1'h0, 20);
    waitFor(5'h01, 1'h0, 20);
    chk("dsm", 64'hA5, dsmReadData);
    $display("test edge wake done");
    wakePinEdge = 1'h0;
    wakePinPolarity = 1'h0;
    nap();
    waitFor(5'h08, 1'h0, 20);
    repeat (6) @(negedge clk);
    chk("asleep", 64'h08, powerState);
    chk("core", 64'h0, coreOn);
    chk("io", 64'h0, switched_io_supply);
    wakeLevel = 1'h0;
    waitFor(5'h01, 1'h0, 30);
    wakePinEnable = 1'h0;
    wakeTimerEnable = 1'h1;
    rtcCompare = rtcCount + 64'h200;
    nap();
    waitFor(5'h08, 1'h0, 20);
    r = rtcCount;
    repeat (32) @(negedge clk);
    chk("slow", rtcIncrement, rtcCount - r);
    waitFor(5'h01, 1'h0, 3000);
    chk("rtc", 64'h1, rtcCount >= rtcCompare);
    wakeTimerEnable = 1'h0;
    $display("test level and timer wake done");
    wdtEnable = 1'h1;
    repeat (4) begin
      wdtArm = 1'h1;
      @(negedge clk);
      wdtArm = 1'h0;
      repeat (12) @(negedge clk);
    end
    chk("armed", 64'h0, chipReset);
    waitFor(5'h01, 1'h1, 40);
    wdtEnable = 1'h0;
    waitFor(5'h01, 1'h0, 20);
    chk("cause", 64'h1, wdtResetCause);
    $display("test watchdog done");
    nap();
    brownOut = 1'h1;
    waitFor(5'h01, 1'h1, 6);
    brownOut = 1'h0;
    waitFor(5'h01, 1'h0, 20);
    chk("cause", 64'h0, wdtResetCause);
    pressReset = 1'h1;
    waitFor(5'h01, 1'h1, 6);
    pressReset = 1'h0;
    waitFor(5'h01, 1'h0, 20);
    $display("test fault resets done");
    summarize();
  end
endmodule // tb_power_supervisor_sleep_controller
`default_nettype wire
